//--- rtl/racc_top.sv
// Register bank front end: bank window, command control, abort and status registers on APB.
`timescale 1ns/1ps
`default_nettype none
`include "racc_regs.svh"
module racc_top #(
  parameter int ADDR_W = 12,
  parameter int WAKE_CYCLES = `RACC_WAKE_CYCLES,
  parameter int CMD_CYCLES = `RACC_CMD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] host_addr_latch,
  output logic [5:0] formed_reg_addr,
  output logic receiver_analog_off,
  output logic soft_sleep_active,
  output logic cmd_busy,
  output logic [3:0] cmd_code
);
  import racc_pkg::*;

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("ADDR_W must lie between 8 and 32");
    end
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 900) begin
      $error("WAKE_CYCLES out of range");
    end
  end

  localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYCLES - 1);

  racc_cmd_if cmd_bus ();

  racc_cmd_engine #(
    .CMD_CYCLES(CMD_CYCLES)
  ) u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .cmd(cmd_bus)
  );

  racc_ctl_regs_type ctl_reg;
  racc_ctl_regs_type ctl_next;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode. Upper address bits must be zero and accesses word aligned.
  // Map by word index: bank window 0x00, command control 0x01, abort 0x10 (write-only),
  // status 0x11 (read-only). Anything else answers with pslverr and reads zero, so that
  // software probing a hole sees an error rather than aliased data.
  logic upper_zero;
  logic [5:0] word_idx;
  logic hit_bank;
  logic hit_cmd;
  logic hit_abort;
  logic hit_status;
  logic hit_any;
  logic access;
  logic setup;
  logic wr_bank;
  logic wr_cmd;
  logic wr_abort;
  logic reinit_active;
  logic [31:0] read_mux;

  always_comb begin
    upper_zero = 1'b1;
    for (int i = 8; i < ADDR_W; i++) begin
      if (paddr[i]) begin
        upper_zero = 1'b0;
      end
    end
  end

  assign word_idx = paddr[7:2];
  assign hit_bank = upper_zero && paddr[1:0] == 2'b00 && word_idx == `RACC_BANK_IDX;
  assign hit_cmd = upper_zero && paddr[1:0] == 2'b00 && word_idx == `RACC_CMD_IDX;
  assign hit_abort = upper_zero && paddr[1:0] == 2'b00 && word_idx == `RACC_ABORT_IDX;
  assign hit_status = upper_zero && paddr[1:0] == 2'b00 && word_idx == `RACC_STATUS_IDX;
  assign hit_any = hit_bank || hit_cmd || hit_abort || hit_status;

  assign setup = psel && !penable;
  assign access = psel && penable;
  // All writable registers are one byte wide, so only lane 0 carries a write.
  assign wr_bank = access && pwrite && hit_bank && pstrb[0];
  assign wr_cmd = access && pwrite && hit_cmd && pstrb[0];
  assign wr_abort = access && pwrite && hit_abort && pstrb[0];

  assign reinit_active = cmd_bus.busy && cmd_bus.running_code == `RACC_CODE_REINIT;

  assign pready = access;
  assign pslverr = access && !hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle and held through the access phase.
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_bank) begin
      read_mux[`RACC_PG_OVR_BIT] = ctl_reg.page_override_enable;
      read_mux[`RACC_PG_NUM_MSB:`RACC_PG_NUM_LSB] = ctl_reg.page_number;
    end else if (hit_cmd) begin
      read_mux[`RACC_RXOFF_BIT] = ctl_reg.receiver_analog_off;
      read_mux[`RACC_SLEEP_BIT] = ctl_reg.soft_sleep_bit;
      read_mux[`RACC_CODE_MSB:`RACC_CODE_LSB] = cmd_bus.running_code;
    end else if (hit_status) begin
      read_mux[5:0] = ctl_reg.formed_reg_addr;
      read_mux[`RACC_ST_BUSY_BIT] = cmd_bus.busy;
      read_mux[`RACC_ST_ASLEEP_BIT] = ctl_reg.soft_sleep_bit && !ctl_reg.waking;
      read_mux[`RACC_ST_WAKING_BIT] = ctl_reg.waking;
    end
    // Reserved bits and the write-only abort register stay zero here.
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctl_next = ctl_reg;
    if (setup && !pwrite) begin
      ctl_next.prdata = read_mux;
    end
    if (ctl_reg.page_override_enable) begin
      ctl_next.formed_reg_addr = {ctl_reg.page_number, host_addr_latch[3:0]};
    end else begin
      ctl_next.formed_reg_addr = host_addr_latch;
    end
    if (wr_bank) begin
      ctl_next.page_override_enable = pwdata[`RACC_PG_OVR_BIT];
      ctl_next.page_number = pwdata[`RACC_PG_NUM_MSB:`RACC_PG_NUM_LSB];
    end
    // Wake-up completion clears the sleep bit unless the host sets it again in the same cycle.
    if (ctl_reg.waking) begin
      if (ctl_reg.wake_cnt == 16'h0000) begin
        ctl_next.waking = 1'b0;
        ctl_next.soft_sleep_bit = 1'b0;
      end else begin
        ctl_next.wake_cnt = ctl_reg.wake_cnt - 16'h0001;
      end
    end
    if (wr_cmd) begin
      ctl_next.receiver_analog_off = pwdata[`RACC_RXOFF_BIT];
      if (pwdata[`RACC_SLEEP_BIT]) begin
        if (!reinit_active) begin
          ctl_next.soft_sleep_bit = 1'b1;
          ctl_next.waking = 1'b0;
        end
      end else if (ctl_reg.soft_sleep_bit && !ctl_reg.waking) begin
        ctl_next.waking = 1'b1;
        ctl_next.wake_cnt = WAKE_LAST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg.page_override_enable <= 1'(`RACC_BANK_RESET >> `RACC_PG_OVR_BIT);
      ctl_reg.page_number <= 2'h0;
      ctl_reg.receiver_analog_off <= 1'(`RACC_CMD_RESET >> `RACC_RXOFF_BIT);
      ctl_reg.soft_sleep_bit <= 1'b0;
      ctl_reg.waking <= 1'b0;
      ctl_reg.wake_cnt <= 16'h0000;
      ctl_reg.formed_reg_addr <= 6'h00;
      ctl_reg.prdata <= 32'h0000_0000;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The engine takes a start on every command write; writes while asleep are still honoured.
  assign cmd_bus.start = wr_cmd;
  assign cmd_bus.start_code = pwdata[`RACC_CODE_MSB:`RACC_CODE_LSB];
  assign cmd_bus.abort = wr_abort && pwdata[`RACC_ABORT_BIT];

  assign prdata = ctl_reg.prdata;
  assign formed_reg_addr = ctl_reg.formed_reg_addr;
  assign receiver_analog_off = ctl_reg.receiver_analog_off;
  assign soft_sleep_active = ctl_reg.soft_sleep_bit && !ctl_reg.waking;
  assign cmd_busy = cmd_bus.busy;
  assign cmd_code = cmd_bus.running_code;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_setup_abort;
  logic rd_setup_cmd;
  logic rd_setup_bank;
  logic rd_setup_status;
  assign rd_setup_abort = setup && !pwrite && hit_abort;
  assign rd_setup_cmd = setup && !pwrite && hit_cmd;
  assign rd_setup_bank = setup && !pwrite && hit_bank;
  assign rd_setup_status = setup && !pwrite && hit_status;

  property p_wo_reads_zero;
    rd_setup_abort |=> (prdata == 32'h0000_0000);
  endproperty
  a_wo_reads_zero: assert property (p_wo_reads_zero) else $error("write-only register read nonzero");

  property p_rfu_zero;
    rd_setup_cmd |=> (prdata[31:6] == 26'h0);
  endproperty
  a_rfu_zero: assert property (p_rfu_zero) else $error("reserved command bits read nonzero");

  property p_bank_holds;
    !wr_bank |=> ($stable(ctl_reg.page_override_enable) && $stable(ctl_reg.page_number));
  endproperty
  a_bank_holds: assert property (p_bank_holds) else $error("bank window changed without a host write");

  property p_status_ignores_write;
    (access && pwrite && hit_status) |=> ($stable(ctl_reg.page_number) && $stable(receiver_analog_off));
  endproperty
  a_status_ignores_write: assert property (p_status_ignores_write) else $error("status write had an effect");

  property p_addr_override;
    ctl_reg.page_override_enable |=>
      (formed_reg_addr == {$past(ctl_reg.page_number), $past(host_addr_latch[3:0])});
  endproperty
  a_addr_override: assert property (p_addr_override) else $error("page override address wrong");

  property p_addr_plain;
    !ctl_reg.page_override_enable |=> (formed_reg_addr == $past(host_addr_latch));
  endproperty
  a_addr_plain: assert property (p_addr_plain) else $error("latch address wrong");

  property p_rx_off_write;
    wr_cmd |=> (receiver_analog_off == $past(pwdata[`RACC_RXOFF_BIT]));
  endproperty
  a_rx_off_write: assert property (p_rx_off_write) else $error("receiver off bit not taken");

  property p_sleep_enter;
    (wr_cmd && pwdata[`RACC_SLEEP_BIT] && !reinit_active) |=> soft_sleep_active;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("soft power-down not entered");

  property p_wake_reads_one;
    (wr_cmd && !pwdata[`RACC_SLEEP_BIT] && soft_sleep_active) |=>
      ctl_reg.soft_sleep_bit ##[0:900] !ctl_reg.soft_sleep_bit;
  endproperty
  a_wake_reads_one: assert property (p_wake_reads_one) else $error("wake-up sequence wrong");

  property p_reinit_refuse;
    (wr_cmd && pwdata[`RACC_SLEEP_BIT] && reinit_active && !ctl_reg.soft_sleep_bit) |=>
      !ctl_reg.soft_sleep_bit;
  endproperty
  a_reinit_refuse: assert property (p_reinit_refuse) else $error("sleep set during reinit");

  property p_cmd_start;
    wr_cmd |=> (cmd_code == $past(pwdata[`RACC_CODE_MSB:`RACC_CODE_LSB]));
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("command code not started");

  // Read data is compared with the state sampled at the setup edge, where prdata is captured.
  property p_bank_read;
    rd_setup_bank |=>
      (prdata == {24'h00_0000, $past(ctl_reg.page_override_enable), 5'h00, $past(ctl_reg.page_number)});
  endproperty
  a_bank_read: assert property (p_bank_read) else $error("bank window read data wrong");

  property p_cmd_read;
    rd_setup_cmd |=>
      (prdata[7:0] == {2'h0, $past(receiver_analog_off), $past(ctl_reg.soft_sleep_bit), $past(cmd_code)});
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command control read data wrong");

  property p_status_read;
    rd_setup_status |=>
      (prdata == {21'h00_0000, $past(ctl_reg.waking), $past(soft_sleep_active), $past(cmd_busy), 2'h0,
                  $past(formed_reg_addr)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong");

  property p_rx_off_holds;
    !wr_cmd |=>
      $stable(receiver_analog_off);
  endproperty
  a_rx_off_holds: assert property (p_rx_off_holds) else $error("receiver off bit changed without a host write");

  property p_unmapped_no_effect;
    (access && pwrite && !hit_any) |=>
      ($stable(ctl_reg.page_override_enable) && $stable(ctl_reg.page_number) && $stable(receiver_analog_off));
  endproperty
  a_unmapped_no_effect: assert property (p_unmapped_no_effect) else $error("unmapped write had an effect");

  property p_sleep_holds;
    (!wr_cmd && !ctl_reg.waking) |=>
      $stable(ctl_reg.soft_sleep_bit);
  endproperty
  a_sleep_holds: assert property (p_sleep_holds) else $error("sleep bit changed on its own");

  property p_waking_shows_one;
    ctl_reg.waking |->
      ctl_reg.soft_sleep_bit;
  endproperty
  a_waking_shows_one: assert property (p_waking_shows_one) else $error("sleep bit cleared during wake-up");

  property p_wake_completes;
    (ctl_reg.waking && ctl_reg.wake_cnt == 16'h0000 && !(wr_cmd && pwdata[`RACC_SLEEP_BIT])) |=>
      (!ctl_reg.soft_sleep_bit && !ctl_reg.waking);
  endproperty
  a_wake_completes: assert property (p_wake_completes) else $error("wake-up did not clear the sleep bit");

  property p_wake_ignored_awake;
    (wr_cmd && !pwdata[`RACC_SLEEP_BIT] && !ctl_reg.soft_sleep_bit) |=>
      (!ctl_reg.soft_sleep_bit && !ctl_reg.waking);
  endproperty
  a_wake_ignored_awake: assert property (p_wake_ignored_awake) else $error("wake-up started while awake");

  property p_abort_ends;
    (cmd_bus.abort && cmd_bus.busy && !cmd_bus.start) |=>
      (cmd_code == `RACC_CODE_IDLE && !cmd_busy);
  endproperty
  a_abort_ends: assert property (p_abort_ends) else $error("abort did not stop the command");

  property p_busy_has_code;
    cmd_busy |->
      (cmd_code != `RACC_CODE_IDLE);
  endproperty
  a_busy_has_code: assert property (p_busy_has_code) else $error("busy with the idle code");

  property p_start_busy;
    (cmd_bus.start && cmd_bus.start_code != `RACC_CODE_IDLE) |=>
      (cmd_busy && cmd_code == $past(cmd_bus.start_code));
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("command start did not run");

  property p_idle_start_stops;
    (cmd_bus.start && cmd_bus.start_code == `RACC_CODE_IDLE) |=>
      !cmd_busy;
  endproperty
  a_idle_start_stops: assert property (p_idle_start_stops) else $error("idle code left the engine busy");

  c_wake_done: cover property (ctl_reg.waking ##1 !ctl_reg.soft_sleep_bit);
  c_reinit_refused: cover property (wr_cmd && pwdata[`RACC_SLEEP_BIT] && reinit_active);
  c_override_used: cover property (ctl_reg.page_override_enable && ctl_reg.page_number == 2'h3);
  c_unmapped: cover property (pslverr);
endmodule
`default_nettype wire

//--- rtl/racc_regs.svh
// Register offsets, field positions, reset values and timing counts of the register access block.
`ifndef RACC_REGS_SVH
`define RACC_REGS_SVH

`define RACC_BANK_IDX 6'h00
`define RACC_CMD_IDX 6'h01
`define RACC_ABORT_IDX 6'h10
`define RACC_STATUS_IDX 6'h11

`define RACC_PG_OVR_BIT 7
`define RACC_PG_NUM_MSB 1
`define RACC_PG_NUM_LSB 0
`define RACC_RXOFF_BIT 5
`define RACC_SLEEP_BIT 4
`define RACC_CODE_MSB 3
`define RACC_CODE_LSB 0
`define RACC_ABORT_BIT 0
`define RACC_ST_BUSY_BIT 8
`define RACC_ST_ASLEEP_BIT 9
`define RACC_ST_WAKING_BIT 10

`define RACC_BANK_RESET 8'h00
`define RACC_CMD_RESET 8'h20

`define RACC_CODE_IDLE 4'h0
`define RACC_CODE_REINIT 4'hf

`define RACC_CLK_PERIOD_NS 20
`define RACC_WAKE_TIME_NS 500
`define RACC_CMD_TIME_NS 200
`define RACC_WAKE_CYCLES ((`RACC_WAKE_TIME_NS + `RACC_CLK_PERIOD_NS - 1) / `RACC_CLK_PERIOD_NS)
`define RACC_CMD_CYCLES ((`RACC_CMD_TIME_NS + `RACC_CLK_PERIOD_NS - 1) / `RACC_CLK_PERIOD_NS)

`endif

//--- rtl/racc_pkg.sv
// Types shared by the register access block and its command engine.
package racc_pkg;

  typedef enum logic [0:0] {
    RACC_ENG_IDLE = 1'b0,
    RACC_ENG_RUN = 1'b1
  } racc_eng_state_type;

  typedef struct packed {
    racc_eng_state_type state;
    logic [3:0] code;
    logic [15:0] count;
    logic done;
  } racc_eng_regs_type;

  typedef struct packed {
    logic page_override_enable;
    logic [1:0] page_number;
    logic receiver_analog_off;
    logic soft_sleep_bit;
    logic waking;
    logic [15:0] wake_cnt;
    logic [5:0] formed_reg_addr;
    logic [31:0] prdata;
  } racc_ctl_regs_type;

endpackage

//--- rtl/racc_cmd_if.sv
// Carrier between the register front end and the command engine.
`timescale 1ns/1ps
`default_nettype none
interface racc_cmd_if;
  logic start;
  logic [3:0] start_code;
  logic abort;
  logic busy;
  logic [3:0] running_code;
  logic done;

  modport ctrl (output start, output start_code, output abort, input busy, input running_code, input done);
  modport engine (input start, input start_code, input abort, output busy, output running_code, output done);
endinterface
`default_nettype wire

//--- rtl/racc_cmd_engine.sv
// Command engine that runs one command at a time and falls back to the idle code when it ends.
`timescale 1ns/1ps
`default_nettype none
`include "racc_regs.svh"
module racc_cmd_engine #(
  parameter int CMD_CYCLES = `RACC_CMD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  racc_cmd_if.engine cmd
);
  import racc_pkg::*;

  initial begin
    // A command must stay busy for at least two cycles after its start for the length check below.
    if (CMD_CYCLES < 2 || CMD_CYCLES > 65535) begin
      $error("CMD_CYCLES out of range");
    end
  end

  localparam logic [15:0] CMD_LAST = 16'(CMD_CYCLES - 1);

  racc_eng_regs_type eng_reg;
  racc_eng_regs_type eng_next;

  ////////////////////////////////////////////////////////////////////////////
  // A new start always wins over the end of the running command.
  always_comb begin
    eng_next = eng_reg;
    eng_next.done = 1'b0;
    unique case (eng_reg.state)
      RACC_ENG_IDLE: begin
      end
      RACC_ENG_RUN: begin
        if (cmd.abort || eng_reg.count == 16'h0000) begin
          eng_next.state = RACC_ENG_IDLE;
          eng_next.code = `RACC_CODE_IDLE;
          eng_next.done = 1'b1;
        end else begin
          eng_next.count = eng_reg.count - 16'h0001;
        end
      end
    endcase
    if (cmd.start) begin
      eng_next.code = cmd.start_code;
      eng_next.count = CMD_LAST;
      eng_next.done = 1'b0;
      eng_next.state = (cmd.start_code == `RACC_CODE_IDLE) ? RACC_ENG_IDLE : RACC_ENG_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_reg <= '{state: RACC_ENG_IDLE, code: `RACC_CODE_IDLE, count: 16'h0000, done: 1'b0};
    end else begin
      eng_reg <= eng_next;
    end
  end

  assign cmd.busy = (eng_reg.state == RACC_ENG_RUN);
  assign cmd.running_code = eng_reg.code;
  assign cmd.done = eng_reg.done;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_cmd_ends_idle;
    (eng_reg.state == RACC_ENG_RUN && eng_reg.count == 16'h0000 && !cmd.start) |=>
      (cmd.running_code == `RACC_CODE_IDLE && !cmd.busy && cmd.done);
  endproperty
  a_cmd_ends_idle: assert property (p_cmd_ends_idle) else $error("command did not return to idle");

  property p_cmd_length;
    (cmd.start && cmd.start_code != `RACC_CODE_IDLE) ##1 (!cmd.start && !cmd.abort) [*2] |->
      cmd.busy;
  endproperty
  a_cmd_length: assert property (p_cmd_length) else $error("command ended too early");

  c_cmd_done: cover property (cmd.busy ##1 cmd.done);
endmodule
`default_nettype wire

//--- test/racc_host_model.sv
// Host model that runs APB cycles and drives the address latch pins.
`timescale 1ns/1ps
`default_nettype none
module racc_host_model #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic [5:0] host_addr_latch
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    host_addr_latch = 6'h00;
  end

  ////////////////////////////////////////////////////////////////
  // Callers keep reserved fields at zero except where a read of them is probed.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so that a stale address or data cannot pass for a held one.
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic set_latch(input logic [5:0] v);
    @(posedge pclk);
    host_addr_latch <= v;
  endtask
endmodule
`default_nettype wire

//--- test/tb_register_access_command_control.sv
// Self-checking testbench for the register access and command control block.
`timescale 1ns/1ps
`default_nettype none
module tb_register_access_command_control;
  localparam int WAKE = 3;
  localparam int CMDC = 12;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] latch;
  logic [5:0] formed;
  logic rx_off;
  logic sleep;
  logic busy;
  logic [3:0] code;
  logic [31:0] q;
  logic err;
  int n;
  int n_fail;
  int samples_checked;

  racc_top #(.ADDR_W(12), .WAKE_CYCLES(WAKE), .CMD_CYCLES(CMDC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_addr_latch(latch), .formed_reg_addr(formed),
    .receiver_analog_off(rx_off), .soft_sleep_active(sleep), .cmd_busy(busy), .cmd_code(code)
  );

  racc_host_model #(.ADDR_W(12)) host (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .host_addr_latch(latch)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The extra nanosecond lets the registered outputs of the write edge land.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, err);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr, input string name);
    host.xfer(1'b0, a, 32'h0, q, err);
    chk(name, q, exp);
    chk("slverr", {31'h0, err}, {31'h0, eerr});
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("rx_off_rst", {31'h0, rx_off}, 32'h1);
    rd(12'h000, 32'h0, 1'b0, "bank_rst");
    rd(12'h004, 32'h20, 1'b0, "cmd_rst");
    wr(12'h000, 32'hff);
    rd(12'h000, 32'h83, 1'b0, "bank_rsvd");
    host.set_latch(6'h2a);
    repeat (2) @(posedge pclk);
    #1;
    chk("formed_ovr", {26'h0, formed}, 32'h3a);
    wr(12'h000, 32'h01);
    @(posedge pclk);
    #1;
    chk("formed_latch", {26'h0, formed}, 32'h2a);
    wr(12'h000, 32'h81);
    wr(12'h044, 32'h7ff);
    rd(12'h044, 32'h1a, 1'b0, "status_ro");
    wr(12'h004, 32'h00);
    chk("rx_on", {31'h0, rx_off}, 32'h0);
    wr(12'h004, 32'h20);
    chk("rx_off", {31'h0, rx_off}, 32'h1);
    for (int c = 0; c < 16; c++) begin
      wr(12'h004, 32'h20 | c);
      chk("code", {28'h0, code}, c);
      chk("busy", {31'h0, busy}, {31'h0, c != 0});
    end
    wr(12'h004, 32'h3f);
    chk("sleep_refused", {31'h0, sleep}, 32'h0);
    rd(12'h004, 32'h2f, 1'b0, "reinit_run");
    wr(12'h004, 32'h23);
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("busy_len", n, CMDC);
    rd(12'h004, 32'h20, 1'b0, "cmd_done");
    wr(12'h004, 32'h25);
    rd(12'h004, 32'h25, 1'b0, "cmd_run");
    wr(12'h040, 32'h01);
    chk("abort", {28'h0, code}, 32'h0);
    rd(12'h040, 32'h0, 1'b0, "wo_read");
    wr(12'h004, 32'h30);
    chk("sleep_on", {31'h0, sleep}, 32'h1);
    rd(12'h004, 32'h30, 1'b0, "sleep_rd");
    wr(12'h004, 32'h20);
    chk("waking", {31'h0, sleep}, 32'h0);
    rd(12'h004, 32'h30, 1'b0, "wake_bit");
    n = 0;
    do begin
      host.xfer(1'b0, 12'h004, 32'h0, q, err);
      n++;
    end while (q[4] !== 1'b0 && n < 20);
    chk("woken", q, 32'h20);
    rd(12'h008, 32'h0, 1'b1, "unmapped");
    wr(12'h00c, 32'h00);
    rd(12'h000, 32'h81, 1'b0, "bank_kept");
    complete_run();
  end
endmodule
`default_nettype wire
